// File: arw_top.sv
// Avionics word receiver, trigger, search and decode record
`timescale 1ns/1ps
module arw_top
  import arw_pkg::*;
#(
  parameter int LS_CYC = LS_BIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Sampled bus halves after threshold
  input  wire logic        line_hi_i,
  input  wire logic        line_lo_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Event pulses
  output logic             trig_o,
  output logic             srch_hit_o,
  // Decode record
  output logic             rec_vld_o,
  output logic [31:0]      rec_start_o,
  output logic [31:0]      rec_stop_o,
  output logic [7:0]       rec_label_o,
  output logic [1:0]       rec_sdi_o,
  output logic [1:0]       rec_ssm_o,
  output logic [DATA_W-1:0] rec_data_o,
  output logic [2:0]       rec_state_o,
  output logic [15:0]      rec_name_o,
  output logic [2:0]       rec_fmt_o
);
  // Register state
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] udiv_r, udiv_nxt;
  logic [31:0] bank_r [NBANK][BANK_W];
  logic [31:0] bank_nxt [NBANK][BANK_W];
  logic [31:0] ltab_r [NLTAB];
  logic [31:0] ltab_nxt [NLTAB];
  logic        armed_r, armed_nxt, trigd_r, trigd_nxt;
  logic [31:0] trig_t_r, trig_t_nxt;
  logic [15:0] wcnt_r, wcnt_nxt;
  logic [7:0]  scnt_r, scnt_nxt;
  // AXI state
  logic [7:0]  aw_a_r, aw_a_nxt, ar_a;
  logic [31:0] w_d_r, w_d_nxt, rdat_nxt;
  logic [3:0]  w_s_r, w_s_nxt;
  logic        awh_r, awh_nxt, wh_r, wh_nxt, bv_nxt, rv_nxt, arr_nxt;
  logic        wr_go;
  // Receiver state
  arw_rx_e     rx_st_r, rx_st_nxt;
  logic [16:0] cnt_r, cnt_nxt, bper, gap_lim;
  logic [5:0]  nb_r, nb_nxt;
  logic [31:0] sh_r, sh_nxt, word_c;
  logic        cod_r, cod_nxt, nul_r;
  logic        bit_c, wstart_c, wend_c, gap_c;
  logic [2:0]  err_c;
  logic [31:0] tnow_r, wst_r;
  // Per condition set
  logic [NBANK-1:0] hit_c, pv_r;
  logic [31:0]      ps_r [NBANK];
  logic [7:0]       lref_c [NBANK];

  // Byte-lane merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // symbolic id resolves to a table label
  function automatic logic [7:0] sym_lab(input logic [31:0] lab_w, input logic [31:0] tab [NLTAB]);
    logic [7:0] r;
    r = lab_w[7:0];
    if (lab_w[L_SYM]) begin
      for (int i = 0; i < NLTAB; i++) begin
        if (tab[i][E_VLD] && tab[i][E_ID+15:E_ID] == lab_w[L_ID+15:L_ID]) begin
          r = tab[i][7:0];
        end
      end
    end
    return r;
  endfunction : sym_lab

  // Register file read view
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == A_CTRL) begin
      r = ctrl_r;
    end else if (a == A_UDIV) begin
      r = {16'h0000, udiv_r};
    end else if (a == A_STAT) begin
      r = {wcnt_r, scnt_r, 4'h0, rx_st_r == RX_WORD, 1'b0, trigd_r, armed_r};
    end else if (a == A_TTIM) begin
      r = trig_t_r;
    end else if (a[7:5] == A_TBANK[7:5]) begin
      r = bank_r[0][a[4:2]];
    end else if (a[7:5] == A_SBANK[7:5]) begin
      r = bank_r[1][a[4:2]];
    end else if (a[7:5] == A_LTAB[7:5]) begin
      r = ltab_r[a[4:2]];
    end
    return r;
  endfunction : rd_mux

  // AXI handshakes; write commits when address and data are both held
  always_comb begin
    aw_a_nxt = aw_a_r;
    w_d_nxt  = w_d_r;
    w_s_nxt  = w_s_r;
    awh_nxt  = awh_r;
    wh_nxt   = wh_r;
    bv_nxt   = s_axi_bvalid_o && !s_axi_bready_i;
    rv_nxt   = s_axi_rvalid_o && !s_axi_rready_i;
    arr_nxt  = s_axi_arready_o;
    rdat_nxt = s_axi_rdata_o;
    ar_a     = s_axi_araddr_i;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_a_nxt = s_axi_awaddr_i;
      awh_nxt  = 1'b1;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_d_nxt = s_axi_wdata_i;
      w_s_nxt = s_axi_wstrb_i;
      wh_nxt  = 1'b1;
    end
    wr_go = awh_r && wh_r && !s_axi_bvalid_o;
    if (wr_go) begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rdat_nxt = rd_mux(ar_a);
      rv_nxt   = 1'b1;
      arr_nxt  = 1'b0;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      arr_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_a_r          <= 8'h00;
      w_d_r           <= 32'h0000_0000;
      w_s_r           <= 4'h0;
      awh_r           <= 1'b0;
      wh_r            <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
    end else begin
      aw_a_r          <= aw_a_nxt;
      w_d_r           <= w_d_nxt;
      w_s_r           <= w_s_nxt;
      awh_r           <= awh_nxt;
      wh_r            <= wh_nxt;
      s_axi_awready_o <= !awh_nxt;
      s_axi_wready_o  <= !wh_nxt;
      s_axi_bvalid_o  <= bv_nxt;
      s_axi_arready_o <= arr_nxt;
      s_axi_rvalid_o  <= rv_nxt;
      s_axi_rdata_o   <= rdat_nxt;
    end
  end

  // All answers OKAY; unmapped reads return zero
  assign s_axi_bresp_o = 2'b00;
  assign s_axi_rresp_o = 2'b00;

  always_comb begin
    case (arw_rate_e'(ctrl_r[C_RATE+1:C_RATE]))
      RATE_HS: bper = 17'(HS_BIT_CYC);
      RATE_LS: bper = 17'(LS_CYC);
      default: bper = {1'b0, udiv_r};
    endcase
    // gap limit follows the bit period
    gap_lim = 17'(bper * GAP_BITS);
  end

  // Bit receiver: a bit starts on leaving the null level
  always_comb begin
    rx_st_nxt = rx_st_r;
    cnt_nxt   = cnt_r;
    nb_nxt    = nb_r;
    sh_nxt    = sh_r;
    cod_nxt   = cod_r;
    wstart_c  = 1'b0;
    wend_c    = 1'b0;
    gap_c     = 1'b0;
    word_c    = sh_r;
    bit_c     = nul_r && (line_hi_i ^ line_lo_i);
    case (rx_st_r)
      RX_IDLE: begin
        if (ctrl_r[C_DEC] && bit_c) begin
          wstart_c  = 1'b1;
          sh_nxt    = {31'h0000_0000, line_hi_i};
          nb_nxt    = 6'h01;
          cnt_nxt   = 17'h00000;
          cod_nxt   = 1'b0;
          rx_st_nxt = RX_WORD;
        end
      end
      RX_WORD: begin
        cnt_nxt = cnt_r + 17'h00001;
        // both halves driven is invalid coding
        if (line_hi_i && line_lo_i) begin
          cod_nxt = 1'b1;
        end
        if (bit_c) begin
          word_c  = sh_r | ({31'h0000_0000, line_hi_i} << nb_r);
          sh_nxt  = word_c;
          nb_nxt  = nb_r + 6'h01;
          cnt_nxt = 17'h00000;
          // word closes at its 32nd bit
          if (nb_r == 6'(WORD_BITS - 1)) begin
            wend_c    = 1'b1;
            rx_st_nxt = RX_IDLE;
          end
        end else if (cnt_r >= gap_lim) begin
          wend_c    = 1'b1;
          gap_c     = 1'b1;
          rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    // even ones count is a parity error
    err_c = {cod_nxt, gap_c, !gap_c && !(^word_c)};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_st_r <= RX_IDLE;
      cnt_r   <= 17'h00000;
      nb_r    <= 6'h00;
      sh_r    <= 32'h0000_0000;
      cod_r   <= 1'b0;
      nul_r   <= 1'b0;
      tnow_r  <= 32'h0000_0000;
      wst_r   <= 32'h0000_0000;
    end else begin
      rx_st_r <= rx_st_nxt;
      cnt_r   <= cnt_nxt;
      nb_r    <= nb_nxt;
      sh_r    <= sh_nxt;
      cod_r   <= cod_nxt;
      nul_r   <= !line_hi_i && !line_lo_i;
      tnow_r  <= tnow_r + 32'h0000_0001;
      if (wstart_c) begin
        wst_r <= tnow_r;
      end
    end
  end

  // Trigger bank 0 and search bank 1 run the same engine
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    assign lref_c[b] = sym_lab(bank_r[b][B_LAB], ltab_r);
    arw_match u_match (
      .wstart_i (wstart_c),
      .wend_i   (wend_c),
      .word_i   (word_c),
      .err_i    (err_c),
      .tvld_i   (pv_r[b]),
      .ttime_i  (wst_r - ps_r[b]),
      .cfg_i    (bank_r[b]),
      .lab_i    (lref_c[b]),
      .hit_o    (hit_c[b])
    );
    // start time of last word with this label
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        ps_r[b] <= 32'h0000_0000;
        pv_r[b] <= 1'b0;
      end else if (wend_c && !gap_c && word_c[7:0] == lref_c[b]) begin
        ps_r[b] <= wst_r;
        pv_r[b] <= 1'b1;
      end
    end
  end

  // Configuration writes and trigger bookkeeping
  always_comb begin
    ctrl_nxt   = ctrl_r;
    udiv_nxt   = udiv_r;
    bank_nxt   = bank_r;
    ltab_nxt   = ltab_r;
    armed_nxt  = armed_r;
    trigd_nxt  = trigd_r;
    trig_t_nxt = trig_t_r;
    wcnt_nxt   = wcnt_r + {15'h0000, wend_c};
    scnt_nxt   = scnt_r + {7'h00, hit_c[1] && ctrl_r[C_DEC]};
    if (armed_r && hit_c[0]) begin
      armed_nxt  = 1'b0;
      trigd_nxt  = 1'b1;
      trig_t_nxt = tnow_r;
    end
    if (wr_go) begin
      if (aw_a_r == A_CTRL) begin
        ctrl_nxt = be_merge(ctrl_r, w_d_r, w_s_r);
        if (ctrl_nxt[C_ARM]) begin
          ctrl_nxt[C_DEC] = 1'b1;
          armed_nxt       = 1'b1;
          trigd_nxt       = 1'b0;
          scnt_nxt        = 8'h00;
        end
      end else if (aw_a_r == A_UDIV) begin
        // Whole low half taken, strobes ignored, so a divider is never half written
        udiv_nxt = w_d_r[15:0];
      end else if (aw_a_r[7:5] == A_TBANK[7:5]) begin
        bank_nxt[0][aw_a_r[4:2]] = be_merge(bank_r[0][aw_a_r[4:2]], w_d_r, w_s_r);
      end else if (aw_a_r[7:5] == A_SBANK[7:5]) begin
        bank_nxt[1][aw_a_r[4:2]] = be_merge(bank_r[1][aw_a_r[4:2]], w_d_r, w_s_r);
      end else if (aw_a_r[7:5] == A_LTAB[7:5]) begin
        ltab_nxt[aw_a_r[4:2]] = be_merge(ltab_r[aw_a_r[4:2]], w_d_r, w_s_r);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r   <= CTRL_RST;
      udiv_r   <= UDIV_RST;
      bank_r   <= '{default: '{default: 32'h0000_0000}};
      ltab_r   <= '{default: 32'h0000_0000};
      armed_r  <= 1'b0;
      trigd_r  <= 1'b0;
      trig_t_r <= 32'h0000_0000;
      wcnt_r   <= 16'h0000;
      scnt_r   <= 8'h00;
    end else begin
      ctrl_r   <= ctrl_nxt;
      udiv_r   <= udiv_nxt;
      bank_r   <= bank_nxt;
      ltab_r   <= ltab_nxt;
      armed_r  <= armed_nxt;
      trigd_r  <= trigd_nxt;
      trig_t_r <= trig_t_nxt;
      wcnt_r   <= wcnt_nxt;
      scnt_r   <= scnt_nxt;
    end
  end

  // Event pulses and per-word record, all registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_o      <= 1'b0;
      srch_hit_o  <= 1'b0;
      rec_vld_o   <= 1'b0;
      rec_start_o <= 32'h0000_0000;
      rec_stop_o  <= 32'h0000_0000;
      rec_label_o <= 8'h00;
      rec_sdi_o   <= 2'h0;
      rec_ssm_o   <= 2'h0;
      rec_data_o  <= {DATA_W{1'b0}};
      rec_state_o <= 3'h0;
      rec_name_o  <= 16'h0000;
      rec_fmt_o   <= 3'h0;
    end else begin
      trig_o     <= armed_r && hit_c[0];
      srch_hit_o <= hit_c[1] && ctrl_r[C_DEC];
      // record start and stop times relative to trigger point
      rec_vld_o  <= wend_c;
      if (wend_c) begin
        // Next trigger time, so a word that fires at its end stops at zero
        rec_start_o <= wst_r - trig_t_nxt;
        rec_stop_o  <= tnow_r - trig_t_nxt;
        rec_label_o <= word_c[7:0];
        rec_sdi_o   <= word_c[WF_SDI+1:WF_SDI];
        rec_ssm_o   <= word_c[WF_SSM+1:WF_SSM];
        rec_data_o  <= word_c[WF_DAT+DATA_W-1:WF_DAT];
        rec_state_o <= err_c;
        rec_name_o  <= 16'h0000;
        rec_fmt_o   <= 3'h0;
        // table gives name id and format
        for (int i = 0; i < NLTAB; i++) begin
          if (ltab_r[i][E_VLD] && ltab_r[i][7:0] == word_c[7:0]) begin
            rec_name_o <= ltab_r[i][E_ID+15:E_ID];
            rec_fmt_o  <= ltab_r[i][E_FMT+2:E_FMT];
          end
        end
      end
    end
  end

  // Checks on the design's own outputs and internal state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_trig_once;
    trig_o |-> !armed_r ##1 !trig_o;
  endproperty
  a_trig_once: assert property (p_trig_once) else $error("trigger fired twice");
  property p_trig_pulse;
    armed_r && hit_c[0] |=> trig_o && trigd_r;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger pulse missing");
  property p_dec_on;
    armed_r |-> ctrl_r[C_DEC];
  endproperty
  a_dec_on: assert property (p_dec_on) else $error("armed without decode");
  property p_parity;
    wend_c && !gap_c |=> rec_vld_o && (rec_state_o[ST_PAR] == !(^$past(word_c)));
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  property p_rec_label;
    wend_c |=> rec_label_o == $past(word_c[7:0]) && rec_data_o == $past(word_c[28:10]);
  endproperty
  a_rec_label: assert property (p_rec_label) else $error("record fields wrong");
  property p_gap;
    rx_st_r == RX_WORD && !bit_c && cnt_r >= gap_lim |=> rec_vld_o && rec_state_o[ST_GAP];
  endproperty
  a_gap: assert property (p_gap) else $error("gap not flagged");
  property p_cnt_bound;
    rx_st_r == RX_WORD |-> cnt_r <= gap_lim;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("idle count past limit");
  property p_srch_start;
    ctrl_r[C_DEC] && bank_r[1][B_TYPE][3:0] == 4'h0 && wstart_c |=> srch_hit_o;
  endproperty
  a_srch_start: assert property (p_srch_start) else $error("word start missed");
  property p_srch_label;
    ctrl_r[C_DEC] && bank_r[1][B_TYPE][2:0] == 3'h2 && wend_c && word_c[7:0] == lref_c[1] |=> srch_hit_o;
  endproperty
  a_srch_label: assert property (p_srch_label) else $error("label match missed");
  c_trig: cover property (trig_o);
  c_gap: cover property (rec_vld_o && rec_state_o[ST_GAP]);
  c_srch: cover property (srch_hit_o ##[1:1000] srch_hit_o);
  c_par: cover property (rec_vld_o && rec_state_o[ST_PAR]);
endmodule : arw_top

// File: arw_pkg.sv
// Constants and types for the avionics word trigger
// How it works
// - Five selectable trigger types per condition set
// - Arming the trigger forces decoding on
// - Word type fires at start or stop
// - Error type fires on any enabled class
// - Even count of ones flags parity error
// - Gap limit derived from the bit rate
// - Both line halves high is coding error
// - Label match, numeric or via symbolic entry
// - Label and data also match SSM bits
// - Label and data also match SDI bits
// - Data slice set by offset and size
// - Slice compared by equal, unequal, in, out
// - Reference bits high, low or ignored
// - Transmission time checked against lower bound
// - Transmission time checked against upper bound
// - Every word emits a full decode record
// - Search uses the same condition engine
// - Trigger fires once, search every match
// - Label table gives name and format
// - Word is 32 bits, parity at top
// - High, low and user bit rates
package arw_pkg;
  // Clock and line timing
  localparam int CLK_NS     = 8;
  localparam int HS_BIT_NS  = 10000;
  localparam int LS_BIT_NS  = 80000;
  localparam int HS_BIT_CYC = HS_BIT_NS / CLK_NS;
  localparam int LS_BIT_CYC = LS_BIT_NS / CLK_NS;
  localparam int GAP_BITS   = 2;
  localparam int WORD_BITS  = 32;
  // Sizes
  localparam int NBANK  = 2;
  localparam int BANK_W = 8;
  localparam int NLTAB  = 8;
  localparam int DATA_W = 19;
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_UDIV  = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_TTIM  = 8'h0C;
  localparam logic [7:0] A_TBANK = 8'h20;
  localparam logic [7:0] A_SBANK = 8'h40;
  localparam logic [7:0] A_LTAB  = 8'h60;
  // Word index inside a condition set
  localparam int B_TYPE  = 0;
  localparam int B_LAB   = 1;
  localparam int B_SLC   = 2;
  localparam int B_DMIN  = 3;
  localparam int B_DMAX  = 4;
  localparam int B_DCARE = 5;
  localparam int B_TMIN  = 6;
  localparam int B_TMAX  = 7;
  // Field positions
  localparam int C_ARM  = 0;
  localparam int C_DEC  = 1;
  localparam int C_RATE = 2;
  localparam int T_STOP = 3;
  localparam int T_ERR  = 4;
  localparam int T_DCND = 8;
  localparam int T_TCND = 10;
  localparam int L_SSM  = 8;
  localparam int L_SDI  = 10;
  localparam int L_SYM  = 12;
  localparam int L_ID   = 16;
  localparam int S_SIZE = 5;
  localparam int WF_SDI = 8;
  localparam int WF_DAT = 10;
  localparam int WF_SSM = 29;
  localparam int ST_PAR = 0;
  localparam int ST_GAP = 1;
  localparam int ST_COD = 2;
  localparam int E_ID   = 8;
  localparam int E_FMT  = 24;
  localparam int E_VLD  = 31;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] UDIV_RST = 16'h04E2;
  // Modes
  typedef enum logic [2:0] {ARW_WORD, ARW_ERR, ARW_LABEL, ARW_LDATA, ARW_TX} arw_type_e;
  typedef enum logic [1:0] {DC_EQ, DC_NE, DC_IN, DC_OUT} arw_dcmp_e;
  typedef enum logic [1:0] {TC_GT, TC_LT, TC_IN, TC_OUT} arw_tcmp_e;
  typedef enum logic [1:0] {RATE_HS, RATE_LS, RATE_USER} arw_rate_e;
  typedef enum logic {RX_IDLE, RX_WORD} arw_rx_e;
endpackage : arw_pkg

// File: arw_match.sv
// Event condition engine shared by trigger and search
`timescale 1ns/1ps
module arw_match
  import arw_pkg::*;
(
  // Word events
  input  wire logic        wstart_i,
  input  wire logic        wend_i,
  input  wire logic [31:0] word_i,
  input  wire logic [2:0]  err_i,
  // Interval measure
  input  wire logic        tvld_i,
  input  wire logic [31:0] ttime_i,
  // Condition set and resolved label
  input  wire logic [31:0] cfg_i [BANK_W],
  input  wire logic [7:0]  lab_i,
  // Result
  output logic             hit_o
);
  arw_type_e         typ;
  logic [DATA_W-1:0] msk;
  logic [DATA_W-1:0] sl;
  logic [DATA_W-1:0] care;
  logic [DATA_W-1:0] dmin;
  logic [DATA_W-1:0] dmax;
  logic [4:0]        off;
  logic [4:0]        sz;
  logic              lab_eq;
  logic              fld_eq;
  logic              d_eq;
  logic              d_in;
  logic              d_ok;
  logic              t_ok;

  // Condition evaluation, purely combinational
  always_comb begin
    typ  = arw_type_e'(cfg_i[B_TYPE][2:0]);
    off  = cfg_i[B_SLC][4:0];
    sz   = cfg_i[B_SLC][S_SIZE+4:S_SIZE];
    msk  = ~({DATA_W{1'b1}} << sz);
    sl   = (word_i[WF_DAT+DATA_W-1:WF_DAT] >> off) & msk;
    care = cfg_i[B_DCARE][DATA_W-1:0] & msk;
    dmin = cfg_i[B_DMIN][DATA_W-1:0] & care;
    dmax = cfg_i[B_DMAX][DATA_W-1:0] & care;
    d_eq = ((sl & care) == dmin);
    d_in = ((sl & care) >= dmin) && ((sl & care) <= dmax);
    case (arw_dcmp_e'(cfg_i[B_TYPE][T_DCND+1:T_DCND]))
      DC_EQ:   d_ok = d_eq;
      DC_NE:   d_ok = !d_eq;
      DC_IN:   d_ok = d_in;
      default: d_ok = !d_in;
    endcase
    case (arw_tcmp_e'(cfg_i[B_TYPE][T_TCND+1:T_TCND]))
      TC_GT:   t_ok = ttime_i > cfg_i[B_TMIN];
      TC_LT:   t_ok = ttime_i < cfg_i[B_TMAX];
      TC_IN:   t_ok = (ttime_i >= cfg_i[B_TMIN]) && (ttime_i <= cfg_i[B_TMAX]);
      default: t_ok = (ttime_i < cfg_i[B_TMIN]) || (ttime_i > cfg_i[B_TMAX]);
    endcase
    lab_eq = (word_i[7:0] == lab_i);
    fld_eq = (word_i[WF_SSM+1:WF_SSM] == cfg_i[B_LAB][L_SSM+1:L_SSM]) &&
             (word_i[WF_SDI+1:WF_SDI] == cfg_i[B_LAB][L_SDI+1:L_SDI]);
    case (typ)
      ARW_WORD:  hit_o = cfg_i[B_TYPE][T_STOP] ? wend_i : wstart_i;
      ARW_ERR:   hit_o = wend_i && |(err_i & cfg_i[B_TYPE][T_ERR+2:T_ERR]);
      ARW_LABEL: hit_o = wend_i && lab_eq;
      ARW_LDATA: hit_o = wend_i && lab_eq && fld_eq && d_ok;
      ARW_TX:    hit_o = wend_i && lab_eq && tvld_i && t_ok;
      default:   hit_o = 1'b0;
    endcase
  end
endmodule : arw_match

// File: arw_tx_model.sv
// Single transmitter model driving the thresholded bus halves
`timescale 1ns/1ps
module arw_tx_model (
  // Clock and line halves
  input  wire logic clk_i,
  output logic      hi_o,
  output logic      lo_o
);
  int half = 10;
  initial begin
    hi_o = 1'b0;
    lo_o = 1'b0;
  end
  task automatic send(input logic [31:0] w, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_i);
      hi_o <= w[i];
      lo_o <= ~w[i];
      repeat (half) @(posedge clk_i);
      hi_o <= 1'b0;
      lo_o <= 1'b0;
      repeat (half - 1) @(posedge clk_i);
    end
    // Idle long enough for a short word to time out
    repeat (3 * half) @(posedge clk_i);
  endtask : send
endmodule : arw_tx_model

// File: arw_top_tb_top.sv
// Self-checking bench for the avionics word trigger
`timescale 1ns/1ps
module arw_top_tb_top;
  import arw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd, w, rs, rp;
  logic hi, lo, awready, wready, bvalid, arready, rvalid, trig, shit, vld;
  logic [1:0] bresp, rresp, sdi, ssm;
  logic [7:0] lab;
  logic [DATA_W-1:0] dat;
  logic [2:0] st, fmt;
  logic [15:0] nm;
  int fail_count = 0, n_tests = 0, ntrig = 0, nsrch = 0, cyc = 0, nexp = 0, t0, s0, nrec = 0;
  arw_tx_model tx_u (.clk_i(clk_i), .hi_o(hi), .lo_o(lo));
  arw_top #(.LS_CYC(40)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .line_hi_i(hi), .line_lo_i(lo),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .trig_o(trig), .srch_hit_o(shit), .rec_vld_o(vld), .rec_start_o(rs), .rec_stop_o(rp),
    .rec_label_o(lab), .rec_sdi_o(sdi), .rec_ssm_o(ssm), .rec_data_o(dat), .rec_state_o(st),
    .rec_name_o(nm), .rec_fmt_o(fmt));
  always #4 clk_i = ~clk_i;
  // Pulse counters and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) ntrig <= ntrig + 1;
    if (shit === 1'b1) nsrch <= nsrch + 1;
    if (vld === 1'b1) nrec <= nrec + 1;
    if (cyc > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Both items offered at once, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    // One edge between calls so bready is never set twice at once
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (awvalid | wvalid | bready);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        rready <= 1'b0;
      end
    end while (arvalid | rready);
  endtask : axr
  // Odd parity unless a fault is asked for
  function automatic logic [31:0] mk(input logic [30:0] b, input logic bad);
    return {~^b ^ bad, b};
  endfunction : mk
  task automatic report_and_stop();
    $display("tests=%0d fails=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(8109));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    axr(A_CTRL, rd);
    check(rd, CTRL_RST);
    axr(A_UDIV, rd);
    check(rd, {16'h0000, UDIV_RST});
    axr(8'hFC, rd);
    check(rd, 32'h0);
    // User rate of 20 cycles per bit
    axw(A_UDIV, 32'h14);
    axw(A_TBANK, 32'h8);
    axw(A_SBANK, 32'h2);
    axw(A_SBANK + 8'h04, 32'h5A);
    axw(A_LTAB, 32'h8312_345A);
    // Arm with decode off; the arm must force it on
    axw(A_CTRL, 32'h9);
    axr(A_CTRL, rd);
    check(rd, 32'hB);
    axr(A_STAT, rd);
    check(rd[1:0], 2'b01);
    for (int i = 0; i < 6; i++) begin
      // Label set before parity so the word stays odd
      w = mk((i % 2 == 1) ? {23'($urandom()), 8'h5A} : 31'($urandom()), 1'b0);
      if (w[7:0] == 8'h5A) nexp++;
      tx_u.send(w, 32);
      check({ssm, dat, sdi, lab}, w[30:0]);
      check(st, 3'b000);
      check(rp - rs, 32'(31 * 20));
      if (i == 0) check(rp, 32'h0000_0000);
    end
    check({fmt, nm}, {3'h3, 16'h1234});
    check(ntrig, 1);
    check(nsrch, nexp);
    // Error trigger on parity class only, search on word start
    axw(A_TBANK, 32'h11);
    axw(A_SBANK, 32'h0);
    axw(A_CTRL, 32'hB);
    t0 = ntrig;
    s0 = nsrch;
    tx_u.send(mk(31'($urandom()), 1'b1), 32);
    check(st, 3'b001);
    check(ntrig, t0 + 1);
    check(rp, 32'h0000_0000);
    tx_u.send(mk(31'($urandom()), 1'b0), 10);
    check(st, 3'b010);
    check(nsrch, s0 + 2);
    check(nrec, 8);
    report_and_stop();
  end
endmodule : arw_top_tb_top
